// ---- hw/rtc_pkg.sv ----
// Function
// R1: without a crystal, the slow clock comes from the internal RC oscillator.
// R2: a 32.768 kHz square wave from the active slow source drives the output pin.
// R3: the slow clock is divided to a one-second tick advancing the seconds counter.
// R4: the 17-bit seconds-of-day counter runs 0 to 86,399 then wraps to zero.
// R5: each seconds wrap increments the 15-bit day counter, reaching up to 32767.
// R6: every tick sets the second tick flag; its mask bit blocks the interrupt.
// R7: alarm flag is raised when seconds and day both equal their alarm values.
// R8: alarm match turns the system on when off; when on it only interrupts.
// R9: software accesses counters right after the tick, or double-reads and compares.
// R10: reading day before seconds, software confirms day did not change meanwhile.
// R11: serial words are 32 bits: read/write bit, six address, null, 24 data.
// R12: each turn-on event, the alarm included, sets its own interrupt flag.
// R13: serial writes load running counters; alarm writes take effect on the next tick.
package rtc_pkg;

    // ----------------------------------------------------------------
    // serial word layout
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 32;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 24;
    localparam logic [5:0] CNT_ADDR_DONE = 6'h07;  // r/w bit plus six address bits taken
    localparam logic [5:0] CNT_DATA_START = 6'h08; // null bit taken, data phase begins
    localparam logic [5:0] CNT_WORD_DONE = 6'h20;  // all 32 bits taken
    localparam logic [5:0] CNT_SPENT = 6'h21;      // word already committed

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [5:0] ADDR_TIME = 6'h14;
    localparam logic [5:0] ADDR_ALARM = 6'h15;
    localparam logic [5:0] ADDR_DAY = 6'h16;
    localparam logic [5:0] ADDR_DAY_ALARM = 6'h17;

    // ----------------------------------------------------------------
    // counter widths, limits and reset values
    // ----------------------------------------------------------------
    localparam int SEC_W = 17;
    localparam int DAY_W = 15;
    localparam logic [16:0] SEC_LAST = 17'h1517F; // 86,399
    localparam logic [16:0] SEC_RESET = 17'h00000;
    localparam logic [14:0] DAY_RESET = 15'h0000;
    localparam logic [16:0] ALARM_SEC_RESET = 17'h00000;
    localparam logic [14:0] ALARM_DAY_RESET = 15'h0000;

    // ----------------------------------------------------------------
    // slow clock division
    // ----------------------------------------------------------------
    localparam int SLOW_CLK_HZ = 32768;
    localparam int TICK_HZ = 1;
    localparam int SLOW_EDGES_PER_TICK = SLOW_CLK_HZ / TICK_HZ;
    localparam int DIV_W = 16;

endpackage

// ---- hw/rtc_serial_port.sv ----
`timescale 1ns/1ps
module rtc_serial_port
    import rtc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic spi_clk,
    input wire logic spi_cs,
    input wire logic spi_mosi,
    output logic spi_miso_out,
    output logic spi_miso_oe,
    output logic [rtc_pkg::ADDR_W-1:0] addr,
    output logic [rtc_pkg::DATA_W-1:0] wr_data,
    output logic wr_en,
    input wire logic [rtc_pkg::DATA_W-1:0] rd_data
);
    import rtc_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] clk_sync_reg;
    logic [1:0] cs_sync_reg;
    logic [1:0] mosi_sync_reg;
    logic clk_prev_reg;

    // two flops per pin before anything reads it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_sync_reg <= 2'h0;
            cs_sync_reg <= 2'h0;
            mosi_sync_reg <= 2'h0;
            clk_prev_reg <= 1'h0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[0], spi_clk};
            cs_sync_reg <= {cs_sync_reg[0], spi_cs};
            mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
            clk_prev_reg <= clk_sync_reg[1];
        end
    end

    // ----------------------------------------------------------------
    // word assembly
    // ----------------------------------------------------------------
    logic [5:0] cnt_reg;
    logic [30:0] shin_reg;
    logic [DATA_W-1:0] shout_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic wr_bit_reg;
    wire cs_on = cs_sync_reg[1];
    wire rise = clk_sync_reg[1] & ~clk_prev_reg;
    wire fall = ~clk_sync_reg[1] & clk_prev_reg;
    wire take_bit = cs_on & rise & (cnt_reg < CNT_WORD_DONE);
    wire data_fall = cs_on & fall & (cnt_reg >= CNT_DATA_START) & (cnt_reg < CNT_WORD_DONE);
    wire commit = cs_on & fall & (cnt_reg == CNT_WORD_DONE); // [R11]
    wire is_write = wr_bit_reg;

    // a dropped select discards the partial word
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 6'h00;
            shin_reg <= 31'h00000000;
        end else if (!cs_on) begin
            cnt_reg <= 6'h00;
        end else if (take_bit) begin
            cnt_reg <= cnt_reg + 6'h01;
            shin_reg <= {shin_reg[29:0], mosi_sync_reg[1]}; // msb first [R11]
        end else if (commit) begin
            cnt_reg <= CNT_SPENT;
        end
    end

    // read data leaves on falling edges once the null bit is in
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shout_reg <= 24'h000000;
        end else if (data_fall && cnt_reg == CNT_DATA_START) begin
            shout_reg <= rd_data;
        end else if (data_fall) begin
            shout_reg <= {shout_reg[DATA_W-2:0], 1'b0};
        end
    end

    // r/w bit and address are held once seven bits are in, since later bits shift them out
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg <= 6'h00;
            wr_bit_reg <= 1'h0;
        end else if (cs_on && cnt_reg == CNT_ADDR_DONE) begin
            addr_reg <= shin_reg[ADDR_W-1:0]; // [R11]
            wr_bit_reg <= shin_reg[ADDR_W];   // [R11]
        end
    end

    assign addr = addr_reg;

    // write pulse on the falling edge of the 32nd clock [R11]
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_en <= 1'h0;
            wr_data <= 24'h000000;
        end else begin
            wr_en <= commit & is_write; // [R11]
            wr_data <= shin_reg[DATA_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // miso: address and null phases read as zero, hi-z while deselected
    // ----------------------------------------------------------------
    wire in_data = (cnt_reg > CNT_DATA_START) || (cnt_reg == CNT_DATA_START && !clk_prev_reg);
    assign spi_miso_oe = cs_on;
    assign spi_miso_out = cs_on & in_data & shout_reg[DATA_W-1];

endmodule

// ---- hw/rtc_day_time_alarm.sv ----
`timescale 1ns/1ps
module rtc_day_time_alarm
    import rtc_pkg::*;
#(
    parameter int SLOW_EDGES = rtc_pkg::SLOW_EDGES_PER_TICK
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic xtal_clk_in,
    input wire logic rc_osc_clk_in,
    input wire logic xtal_present,
    output logic slow_clock_out,
    input wire logic spi_clk,
    input wire logic spi_cs,
    input wire logic spi_mosi,
    output logic spi_miso_out,
    output logic spi_miso_oe,
    input wire logic second_tick_mask,
    input wire logic second_tick_clear,
    input wire logic alarm_match_clear,
    input wire logic system_on,
    output logic second_tick_irq,
    output logic alarm_match_irq,
    output logic second_tick_int,
    output logic alarm_int,
    output logic turn_on_event
);
    import rtc_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers for the slow clock sources, crystal-present and system-on
    // ----------------------------------------------------------------
    logic [1:0] xtal_sync_reg;
    logic [1:0] rc_sync_reg;
    logic [1:0] present_sync_reg;
    logic [1:0] on_sync_reg;

    // the clock source, crystal-present and system-on levels pass two flops first
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_sync_reg <= 2'h0;
            rc_sync_reg <= 2'h0;
            present_sync_reg <= 2'h0;
            on_sync_reg <= 2'h0;
        end else begin
            xtal_sync_reg <= {xtal_sync_reg[0], xtal_clk_in};
            rc_sync_reg <= {rc_sync_reg[0], rc_osc_clk_in};
            present_sync_reg <= {present_sync_reg[0], xtal_present};
            on_sync_reg <= {on_sync_reg[0], system_on};
        end
    end

    // ----------------------------------------------------------------
    // slow clock source selection
    // ----------------------------------------------------------------
    logic slow_prev_reg;
    wire use_xtal = present_sync_reg[1];
    wire slow_level = use_xtal ? xtal_sync_reg[1] : rc_sync_reg[1]; // [R1]
    wire slow_edge = slow_level & ~slow_prev_reg;

    // the registered level doubles as the square wave on the pin
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_prev_reg <= 1'h0;
        end else begin
            slow_prev_reg <= slow_level;
        end
    end

    assign slow_clock_out = slow_prev_reg; // [R2]

    // ----------------------------------------------------------------
    // one-second divider
    // ----------------------------------------------------------------
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOW_EDGES - 1);
    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;
    logic tick;

    // counts active slow-clock edges; the last one of a second ticks
    assign tick = slow_edge & (div_reg == DIV_LAST); // [R3]
    assign div_next = tick ? '0 : (slow_edge ? div_reg + 1'b1 : div_reg);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    // ----------------------------------------------------------------
    // serial register port
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic [DATA_W-1:0] reg_rdata;

    rtc_serial_port u_port (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .spi_clk(spi_clk),
        .spi_cs(spi_cs),
        .spi_mosi(spi_mosi),
        .spi_miso_out(spi_miso_out),
        .spi_miso_oe(spi_miso_oe),
        .addr(reg_addr),
        .wr_data(reg_wdata),
        .wr_en(reg_wr),
        .rd_data(reg_rdata)
    );

    // write strobes per register
    wire wr_time = reg_wr & (reg_addr == ADDR_TIME);
    wire wr_alarm = reg_wr & (reg_addr == ADDR_ALARM);
    wire wr_day = reg_wr & (reg_addr == ADDR_DAY);
    wire wr_day_alarm = reg_wr & (reg_addr == ADDR_DAY_ALARM);

    // ----------------------------------------------------------------
    // seconds-of-day and day counters
    // ----------------------------------------------------------------
    logic [SEC_W-1:0] seconds_of_day_counter_reg;
    logic [SEC_W-1:0] seconds_of_day_counter_next;
    logic [DAY_W-1:0] day_counter_reg;
    logic [DAY_W-1:0] day_counter_next;
    wire sec_wrap = tick & (seconds_of_day_counter_reg == SEC_LAST);

    // a serial write overrides a tick in the same cycle
    assign seconds_of_day_counter_next = wr_time ? reg_wdata[SEC_W-1:0] // [R13]
        : (sec_wrap ? SEC_RESET                                      // [R4]
        : (tick ? seconds_of_day_counter_reg + 1'b1 : seconds_of_day_counter_reg)); // [R3]
    assign day_counter_next = wr_day ? reg_wdata[DAY_W-1:0] // [R13]
        : (sec_wrap ? day_counter_reg + 1'b1 : day_counter_reg); // [R5]

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seconds_of_day_counter_reg <= SEC_RESET;
            day_counter_reg <= DAY_RESET;
        end else begin
            seconds_of_day_counter_reg <= seconds_of_day_counter_next;
            day_counter_reg <= day_counter_next;
        end
    end

    // ----------------------------------------------------------------
    // alarm compare values
    // ----------------------------------------------------------------
    logic [SEC_W-1:0] alarm_seconds_value_reg;
    logic [DAY_W-1:0] alarm_day_value_reg;

    // new compare values are used from the next tick on
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_seconds_value_reg <= ALARM_SEC_RESET;
            alarm_day_value_reg <= ALARM_DAY_RESET;
        end else begin
            if (wr_alarm) begin
                alarm_seconds_value_reg <= reg_wdata[SEC_W-1:0]; // [R13]
            end
            if (wr_day_alarm) begin
                alarm_day_value_reg <= reg_wdata[DAY_W-1:0]; // [R13]
            end
        end
    end

    // ----------------------------------------------------------------
    // read back mux, unused bits and unmapped addresses read zero
    // ----------------------------------------------------------------
    wire [DATA_W-1:0] rd_time = {{(DATA_W-SEC_W){1'b0}}, seconds_of_day_counter_reg};
    wire [DATA_W-1:0] rd_alarm = {{(DATA_W-SEC_W){1'b0}}, alarm_seconds_value_reg};
    wire [DATA_W-1:0] rd_day = {{(DATA_W-DAY_W){1'b0}}, day_counter_reg};
    wire [DATA_W-1:0] rd_day_alarm = {{(DATA_W-DAY_W){1'b0}}, alarm_day_value_reg};

    assign reg_rdata = (reg_addr == ADDR_TIME) ? rd_time
        : (reg_addr == ADDR_ALARM) ? rd_alarm
        : (reg_addr == ADDR_DAY) ? rd_day
        : (reg_addr == ADDR_DAY_ALARM) ? rd_day_alarm
        : '0;

    // ----------------------------------------------------------------
    // alarm match, checked in the cycle after each tick
    // ----------------------------------------------------------------
    logic tick_d_reg;
    wire match_now = (seconds_of_day_counter_reg == alarm_seconds_value_reg)
        & (day_counter_reg == alarm_day_value_reg);
    wire alarm_hit = tick_d_reg & match_now; // [R7]

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_d_reg <= 1'h0;
        end else begin
            tick_d_reg <= tick;
        end
    end

    // ----------------------------------------------------------------
    // sticky flags, where a set in the clear cycle wins, and the one-cycle turn-on pulse
    // ----------------------------------------------------------------
    logic tick_flag_reg;
    logic alarm_flag_reg;
    logic turn_on_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_flag_reg <= 1'h0;
            alarm_flag_reg <= 1'h0;
            turn_on_reg <= 1'h0;
        end else begin
            tick_flag_reg <= tick | (tick_flag_reg & ~second_tick_clear); // [R6]
            alarm_flag_reg <= alarm_hit | (alarm_flag_reg & ~alarm_match_clear); // [R7] [R12]
            turn_on_reg <= alarm_hit & ~on_sync_reg[1]; // [R8]
        end
    end

    assign second_tick_irq = tick_flag_reg;
    assign alarm_match_irq = alarm_flag_reg;
    assign second_tick_int = tick_flag_reg & ~second_tick_mask; // [R6]
    // the alarm only interrupts the processor while the system is on
    assign alarm_int = alarm_flag_reg & on_sync_reg[1]; // [R8]
    assign turn_on_event = turn_on_reg;

endmodule

// ---- test/rtc_props.sv ----
`timescale 1ns/1ps
module rtc_props (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic spi_cs,
    input wire logic spi_miso_oe,
    input wire logic second_tick_mask,
    input wire logic second_tick_clear,
    input wire logic alarm_match_clear,
    input wire logic second_tick_irq,
    input wire logic alarm_match_irq,
    input wire logic second_tick_int,
    input wire logic alarm_int,
    input wire logic turn_on_event
);
    // ----
    // flag, event and serial output checks
    // ----
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    a_tick_int_mask: assert property (second_tick_int == (second_tick_irq && !second_tick_mask))
        else $error("tick interrupt is not flag and not mask");
    a_tick_flag_held: assert property ($fell(second_tick_irq) |->
        $past(second_tick_clear) || $past(second_tick_clear, 2) || $past(second_tick_clear, 3))
        else $error("tick flag dropped without a clear");
    a_alarm_flag_held: assert property ($fell(alarm_match_irq) |->
        $past(alarm_match_clear) || $past(alarm_match_clear, 2) || $past(alarm_match_clear, 3))
        else $error("alarm flag dropped without a clear");
    a_alarm_int_flag: assert property (alarm_int |-> alarm_match_irq)
        else $error("alarm interrupt without alarm flag");
    a_turn_on_once: assert property (turn_on_event |=> !turn_on_event)
        else $error("turn-on event longer than one cycle");
    a_turn_on_cause: assert property (turn_on_event |-> alarm_match_irq && !alarm_int)
        else $error("turn-on event without flag or while on");
    a_miso_release: assert property (!spi_cs [*4] |-> !spi_miso_oe)
        else $error("data out driven while not selected");
    a_miso_drive: assert property (spi_cs [*4] |-> spi_miso_oe)
        else $error("data out not driven while selected");
endmodule
bind rtc_day_time_alarm rtc_props u_props (.ref_clk, .rst_n, .spi_cs, .spi_miso_oe, .second_tick_mask,
    .second_tick_clear, .alarm_match_clear, .second_tick_irq, .alarm_match_irq, .second_tick_int,
    .alarm_int, .turn_on_event);

// ---- test/rtc_host_model.sv ----
`timescale 1ns/1ps
module rtc_host_model (
    input wire logic ref_clk,
    input wire logic miso_line,
    output logic spi_clk,
    output logic spi_cs,
    output logic spi_mosi
);
    // ----
    // serial word master
    // ----
    initial begin
        spi_clk = 1'b0;
        spi_cs = 1'b0;
        spi_mosi = 1'b0;
    end
    // one whole word: r/w, address, null, data, msb first; half period 5 cycles
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [23:0] d, output logic [23:0] q);
        logic [31:0] w;
        w = {wr, a, 1'b0, d};
        q = 24'h000000;
        @(negedge ref_clk);
        spi_cs = 1'b1;
        for (int i = 31; i >= 0; i--) begin
            spi_mosi = w[i];
            repeat (5) @(negedge ref_clk);
            if (i < 24) q[i] = miso_line;
            spi_clk = 1'b1;
            repeat (5) @(negedge ref_clk);
            spi_clk = 1'b0;
        end
        repeat (10) @(negedge ref_clk);
        spi_cs = 1'b0;
        spi_mosi = ~spi_mosi;
        repeat (5) @(negedge ref_clk);
    endtask
    // counters run on their own clock, so a second read counts if it matches the first, else a third read is taken
    task automatic read_stable(input logic [5:0] a, output logic [23:0] q);
        logic [23:0] p;
        xfer(1'b0, a, 24'($urandom), p);
        xfer(1'b0, a, 24'($urandom), q);
        if (q !== p) xfer(1'b0, a, 24'($urandom), q);
    endtask
endmodule

// ---- test/rtc_day_time_alarm_bench.sv ----
`timescale 1ns/1ps
module rtc_day_time_alarm_bench;
    import rtc_pkg::*;
    localparam int SLOW = 4;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic xtal_clk_in = 1'b0;
    logic rc_osc_clk_in = 1'b0;
    logic xtal_present = 1'b1;
    logic second_tick_mask = 1'b0;
    logic second_tick_clear = 1'b0;
    logic alarm_match_clear = 1'b0;
    logic system_on = 1'b0;
    logic flip = 1'b0;
    wire spi_clk, spi_cs, spi_mosi, miso_line;
    logic slow_clock_out, spi_miso_out, spi_miso_oe, second_tick_irq;
    logic alarm_match_irq, second_tick_int, alarm_int, turn_on_event;
    int n_errors = 0;
    int comparisons = 0;
    int n_on = 0, n_aint = 0, n_slow = 0, xc = 0, rc = 0, gap = 0, on0, ai0, sl0;
    longint t_last = 0;
    logic [16:0] exp_sec = 17'h00000, v;
    logic [14:0] exp_day = 15'h0000, d;
    logic [23:0] q;
    logic [31:0] seed;
    logic [5:0] regs [4] = '{ADDR_TIME, ADDR_DAY, ADDR_ALARM, ADDR_DAY_ALARM};
    // ----
    // design and host
    // ----
    rtc_day_time_alarm #(.SLOW_EDGES(SLOW)) u_dut (
        .ref_clk, .rst_n, .xtal_clk_in, .rc_osc_clk_in, .xtal_present, .slow_clock_out,
        .spi_clk, .spi_cs, .spi_mosi, .spi_miso_out, .spi_miso_oe, .second_tick_mask,
        .second_tick_clear, .alarm_match_clear, .system_on, .second_tick_irq,
        .alarm_match_irq, .second_tick_int, .alarm_int, .turn_on_event
    );
    rtc_host_model u_host (.ref_clk, .miso_line, .spi_clk, .spi_cs, .spi_mosi);
    // ----
    // clocks, line resolution and tallies
    // ----
    always #5 ref_clk = ~ref_clk;
    // crystal period 200 cycles, rc period 260
    always @(negedge ref_clk) begin
        xc <= (xc == 99) ? 0 : xc + 1;
        rc <= (rc == 129) ? 0 : rc + 1;
        if (xc == 99) xtal_clk_in <= ~xtal_clk_in;
        if (rc == 129) rc_osc_clk_in <= ~rc_osc_clk_in;
        flip <= ~flip;
    end
    // a released data line shows a changing pattern
    assign miso_line = spi_miso_oe ? spi_miso_out : flip;
    // event tallies
    always @(posedge ref_clk) begin
        if (turn_on_event === 1'b1) n_on <= n_on + 1;
        if (alarm_int === 1'b1) n_aint <= n_aint + 1;
        if ($rose(slow_clock_out)) n_slow <= n_slow + 1;
    end
    // ----
    // checking tasks
    // ----
    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic hang();
        n_errors++;
        $display("MISMATCH t=%0t wait ran out", $time);
        summarize();
    endtask
    // clear the tick flag, wait for the next tick, advance the expected time
    task automatic sync();
        @(negedge ref_clk);
        second_tick_clear = 1'b1;
        second_tick_mask = 1'($urandom);
        for (int k = 0; second_tick_irq !== 1'b0; k++) begin
            if (k > 20) hang();
            @(negedge ref_clk);
        end
        second_tick_clear = 1'b0;
        for (int k = 0; second_tick_irq !== 1'b1; k++) begin
            if (k > 3000) hang();
            @(negedge ref_clk);
        end
        gap = int'(($time - t_last) / 10);
        t_last = $time;
        exp_sec = (exp_sec == SEC_LAST) ? SEC_RESET : exp_sec + 17'h00001;
        exp_day = exp_day + 15'(exp_sec == SEC_RESET);
        check(24'(second_tick_int), 24'(!second_tick_mask), "tick int");
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        seed = $urandom(32'h78EE);
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        // reset values; reads carry junk data that must not land
        foreach (regs[i]) begin
            u_host.xfer(1'b0, regs[i], 24'($urandom), q);
            check(q, 24'h000000, "reset value");
        end
        u_host.xfer(1'b1, 6'h3F, 24'hFFFFFF, q);
        u_host.xfer(1'b0, 6'h3F, 24'h000000, q);
        check(q, 24'h000000, "unmapped");
        // alarm registers at their widths, boundary values first
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? SEC_LAST : 17'($urandom_range(86399, 0));
            d = (i == 0) ? 15'h7FFF : 15'($urandom);
            u_host.xfer(1'b1, ADDR_ALARM, 24'(v), q);
            u_host.xfer(1'b1, ADDR_DAY_ALARM, 24'(d), q);
            u_host.xfer(1'b0, ADDR_ALARM, 24'($urandom), q);
            check(q, 24'(v), "alarm seconds");
            u_host.xfer(1'b0, ADDR_DAY_ALARM, 24'($urandom), q);
            check(q, 24'(d), "alarm day");
        end
        // counters loaded right after a tick, then a rollover
        sync();
        exp_day = 15'($urandom_range(32766, 0));
        u_host.xfer(1'b1, ADDR_DAY, 24'(exp_day), q);
        sync();
        exp_sec = SEC_LAST - 17'h00001;
        u_host.xfer(1'b1, ADDR_TIME, 24'(exp_sec), q);
        sync();
        sync();
        check(24'(gap), 24'(SLOW * 200), "tick spacing");
        u_host.read_stable(ADDR_TIME, q);
        check(q, 24'(exp_sec), "seconds rollover");
        sync();
        u_host.xfer(1'b0, ADDR_DAY, 24'($urandom), q);
        check(q, 24'(exp_day), "day count");
        // alarm: wrong day, then a match while off, then while on
        for (int r = 0; r < 3; r++) begin
            system_on = (r == 2);
            sync();
            alarm_match_clear = 1'b1;
            @(negedge ref_clk);
            alarm_match_clear = 1'b0;
            u_host.xfer(1'b1, ADDR_DAY_ALARM, 24'(exp_day) + 24'(r == 0), q);
            sync();
            u_host.xfer(1'b1, ADDR_ALARM, 24'(exp_sec + 17'h00002), q);
            on0 = n_on;
            ai0 = n_aint;
            repeat (3) sync();
            check(24'(alarm_match_irq), 24'(r != 0), "alarm flag");
            check(24'(n_on - on0), 24'(r == 1), "turn-on pulses");
            check(24'(n_aint > ai0), 24'(r == 2), "alarm int");
        end
        // slow output follows the crystal, then the rc oscillator
        for (int s = 0; s < 2; s++) begin
            xtal_present = (s == 0);
            repeat (300) @(negedge ref_clk);
            sl0 = n_slow;
            repeat (2600) @(negedge ref_clk);
            check(24'(n_slow - sl0), s ? 24'h00000A : 24'h00000D, "slow edges");
        end
        sync();
        sync();
        check(24'(gap), 24'(SLOW * 260), "rc tick spacing");
        summarize();
    end
endmodule
